//--- tb/bos_modem.sv
// behavioural synchronous modem: free bit clocks, serial data both ways
`timescale 1ns/1ps
`default_nettype none
module bos_modem (
   // bit clocks toward the adapter
   output var logic tx_clk,
   output var logic rx_clk,
   // serial data
   output var logic rx_data,
   input  wire logic tx_line,
   // capture result
   output var logic seen_a5
);
   logic       busy = 1'b0;
   logic [7:0] sh   = 8'h00;
   // 80 ns clocks, offset so no edge meets the core clock
   initial begin
      tx_clk = 1'b0;
      #7;
      forever #40 tx_clk = ~tx_clk;
   end
   initial begin
      rx_clk = 1'b0;
      #13;
      forever #40 rx_clk = ~rx_clk;
   end
   initial begin
      rx_data = 1'b0;
      seen_a5 = 1'b0;
   end
   // idle line toggles every bit so no sync pattern forms by accident
   always @(posedge rx_clk) if (!busy) rx_data <= ~rx_data;
   // launch on the rising edge, stable for the falling-edge sample
   task automatic send_byte(input logic [7:0] b);
      busy = 1'b1;
      for (int i = 0; i < 8; i++) begin // lsb first, no parity bit
         @(posedge rx_clk);
         rx_data <= b[i];
      end
      @(negedge rx_clk);
      busy = 1'b0;
   endtask
   // transmit bits taken half a bit after launch
   always @(negedge tx_clk) begin
      sh <= {tx_line, sh[7:1]};
      if ({tx_line, sh[7:1]} === 8'ha5) seen_a5 <= 1'b1;
   end
endmodule
`default_nettype wire

//--- tb/bos_output_sequencer_sva.sv
// pin-level assertions for the output sequencer
`timescale 1ns/1ps
`default_nettype none
module bos_output_sequencer_sva (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // apb handshake
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   // receive port
   input wire logic       rx_avail_clear,
   input wire logic       rx_read_enable,
   input wire logic [7:0] rx_char_out,
   input wire logic [7:0] rx_char_oe_n,
   input wire logic       rx_char_ready,
   input wire logic       rx_overrun_flag,
   // function strobes
   input wire logic       out_data_request,
   input wire logic       status_input_request,
   input wire logic       crc_shift_right,
   input wire logic       crc_accum,
   input wire logic       crc_reset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // apb answers the cycle after setup and never outside an access
   property p_apb_answer; psel && !penable |=> pready; endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb setup not answered");
   property p_apb_access; pready |-> psel && penable; endproperty
   a_apb_access: assert property (p_apb_access) else $error("pready outside an access");
   // read enable switches the drivers one cycle later
   property p_oe_on; rx_read_enable |=> rx_char_oe_n == 8'h00; endproperty
   a_oe_on: assert property (p_oe_on) else $error("receive drivers not on");
   property p_oe_off; !rx_read_enable |=> rx_char_oe_n == 8'hff && rx_char_out == 8'h00; endproperty
   a_oe_off: assert property (p_oe_off) else $error("receive drivers not off");
   // data-available drops only on a clear and otherwise holds
   property p_rdy_fall; $fell(rx_char_ready) |-> $past(rx_avail_clear); endproperty
   a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell without clear");
   property p_rdy_hold; rx_char_ready && !rx_avail_clear |=> rx_char_ready; endproperty
   a_rdy_hold: assert property (p_rdy_hold) else $error("ready lost without clear");
   // overrun needs an unread character already waiting
   property p_ovr;
      $rose(rx_overrun_flag) |-> $past(rx_char_ready) || $past(rx_char_ready, 2);
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun with no unread character");
   // one function per word, so a status request never shares its cycle
   property p_one_fn;
      status_input_request |-> !(out_data_request || crc_reset || crc_accum || crc_shift_right);
   endproperty
   a_one_fn: assert property (p_one_fn) else $error("two functions in one cycle");
   c_apb: cover property (psel && penable && pready);
   c_ovr: cover property ($rose(rx_overrun_flag));
   c_sir: cover property (status_input_request);
   c_odr: cover property (out_data_request);
endmodule
bind bos_output_sequencer bos_output_sequencer_sva u_bos_output_sequencer_sva (.*);
`default_nettype wire

//--- tb/bos_output_sequencer_tb.sv
// self-checking bench: registers, receive path, sequencer program
`timescale 1ns/1ps
`default_nettype none
module bos_output_sequencer_tb;
   // design pins with their time-zero values
   logic        ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, rx_char_out, rx_char_oe_n, out_shift_data = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, seen_a5, sct_low = 1'b0, prog_on = 1'b0;
   logic        modem_tx_clk, modem_rx_clk, modem_rx_data, tx_serial_line, sync_sent_flag;
   logic        self_test_clock = 1'b0, terminal_side_enable = 1'b1;
   logic        rx_avail_clear = 1'b0, rx_read_enable = 1'b0;
   logic        rx_char_ready, rx_overrun_flag, rx_parity_fault;
   logic        out_shift_load_clk = 1'b0, srl_busy = 1'b1, read_strobe = 1'b0;
   logic        write_strobe = 1'b0, strobe_done = 1'b0, crc_shift_done = 1'b0;
   logic        byte_count_nz = 1'b0, out_data_request, status_input_request;
   logic        status_underflow_en_n, status_done_en_n, crc_shift_right, crc_accum, crc_reset;
   logic [3:0]  cnt [5] = '{default: 4'h0};
   logic [23:0] prog [15];
   int          bad_count = 0, comparisons = 0, n;

   bos_output_sequencer #(.TIMER_CYCLES(50)) u_bos_output_sequencer (.*);
   bos_modem u_bos_modem (.tx_clk(modem_tx_clk), .rx_clk(modem_rx_clk),
      .rx_data(modem_rx_data), .tx_line(tx_serial_line), .seen_a5(seen_a5));

   // 100 mhz core clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // count function pulses; a doubled pulse shows as a count of two
   always @(posedge ref_clk) begin
      if (!rst) begin
         cnt[0] <= cnt[0] + {3'h0, crc_shift_right};
         cnt[1] <= cnt[1] + {3'h0, crc_accum};
         cnt[2] <= cnt[2] + {3'h0, crc_reset};
         cnt[3] <= cnt[3] + {3'h0, status_input_request};
         cnt[4] <= cnt[4] + {3'h0, out_data_request};
         if (prog_on && sync_sent_flag === 1'b0) sct_low <= 1'b1;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; waits for pready however long the slave takes
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // poll status until the program counter arrives, then expect a stall there
   task automatic wait_pc(input logic [7:0] p);
      for (n = 0; n < 60; n++) begin
         apb(1'b0, 8'h08, 32'h0);
         if (rd[23:16] === p) break;
      end
      chk("pc_stall", {23'h0, p, 1'b1}, {23'h0, rd[23:16], rd[0]});
   endtask
   task automatic wait_rx(input logic [7:0] c);
      for (n = 0; n < 300 && rx_char_out !== c; n++) @(posedge ref_clk);
      @(posedge ref_clk);
   endtask
   task automatic pulse_clear;
      rx_avail_clear <= 1'b1;
      @(posedge ref_clk);
      rx_avail_clear <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a hang costs far more than the few hundred cycles the tests need
   initial begin
      #200000;
      bad_count++;
      $display("ERROR watchdog expected finish seen timeout");
      tally_and_finish;
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl_reset", 32'h0, rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("mode_reset", 32'h18, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      // 8 bits, no parity, so the modem sends plain bytes
      apb(1'b1, 8'h04, 32'h38);
      apb(1'b0, 8'h04, 32'h0);
      chk("mode", 32'h38, rd);
      rx_read_enable <= 1'b1;
      // a zero byte keeps the hunt from matching early, then sync and data
      fork
         begin
            u_bos_modem.send_byte(8'h00);
            u_bos_modem.send_byte(8'hff);
            u_bos_modem.send_byte(8'h3c);
            u_bos_modem.send_byte(8'h5a);
            u_bos_modem.send_byte(8'hc3);
         end
      join_none
      wait_rx(8'h3c);
      chk("rx_3c", {23'h0, 1'b1, 8'h3c}, {23'h0, rx_char_ready, rx_char_out});
      pulse_clear;
      chk("rx_clear", 32'h0, {31'h0, rx_char_ready});
      wait_rx(8'h5a);
      chk("rx_5a", {22'h0, 2'b10, 8'h5a}, {22'h0, rx_char_ready, rx_parity_fault, rx_char_out});
      wait_rx(8'hc3);
      chk("rx_overrun", {23'h0, 1'b1, 8'hc3}, {23'h0, rx_overrun_flag, rx_char_out});
      rx_read_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("rx_off", 32'hff00, {16'h0, rx_char_oe_n, rx_char_out});
      chk("sync_idle", 32'h1, {31'h0, sync_sent_flag});
      // crc, crc, crc clear, status, request; six waits; taken jump to 13; load a5; park
      prog = '{24'h000002, 24'h000003, 24'h000006, 24'h000005, 24'h000000,
               24'h001587, 24'h001607, 24'h001707, 24'h001787, 24'h001307, 24'h001507,
               24'h000e8d, 24'h001207, 24'ha54007, 24'h001207};
      apb(1'b1, 8'h0c, 32'h0);
      foreach (prog[i]) apb(1'b1, 8'h10, {8'h00, prog[i]});
      prog_on <= 1'b1;
      write_strobe <= 1'b1;
      apb(1'b1, 8'h00, 32'h4);
      // each wait is released by its own test input
      for (int i = 0; i < 6; i++) begin
         wait_pc(8'(5 + i));
         case (i)
            0: srl_busy <= 1'b0;
            1: read_strobe <= 1'b1;
            2: crc_shift_done <= 1'b1;
            3: strobe_done <= 1'b1;
            4: byte_count_nz <= 1'b1;
            default: out_shift_load_clk <= 1'b1;
         endcase
      end
      wait_pc(8'd14);
      chk("fn_pulses", 32'h11111, {12'h0, cnt[0], cnt[1], cnt[2], cnt[3], cnt[4]});
      chk("sir_enables", 32'h0, {30'h0, status_underflow_en_n, status_done_en_n});
      for (n = 0; n < 400 && seen_a5 !== 1'b1; n++) @(posedge ref_clk);
      chk("tx_a5", 32'h3, {30'h0, seen_a5, sct_low});
      tally_and_finish;
   end
endmodule
`default_nettype wire

//--- verilog/bos_map.svh
// register offsets, field positions, reset values and timing for the output sequencer
`ifndef BOS_MAP_SVH
`define BOS_MAP_SVH
// apb byte offsets
`define BOS_CTRL_OFF      8'h00
`define BOS_MODE_OFF      8'h04
`define BOS_STATUS_OFF    8'h08
`define BOS_PADDR_OFF     8'h0c
`define BOS_PDATA_OFF     8'h10
// control register bits
`define BOS_CTRL_XMIT     0
`define BOS_CTRL_BLKCNT   1
`define BOS_CTRL_RUN      2
// mode register bits
`define BOS_MODE_LOOP     0
`define BOS_MODE_TTEST    1
`define BOS_MODE_UNTEST   2
`define BOS_MODE_WLLO     3
`define BOS_MODE_WLHI     4
`define BOS_MODE_NOPAR    5
`define BOS_MODE_SENSE    6
// reset values
`define BOS_CTRL_RST      3'h0
`define BOS_MODE_RST      7'h18
`define BOS_SYNC_RST      8'hff
// transmit timer: one second at 100 mhz
`define BOS_TIMER_S       1
`define BOS_CLK_HZ        100000000
`endif

//--- verilog/bos_output_sequencer.sv
// microprogrammed transmit sequencer with synchronous receiver/transmitter
//
// Function
// - receiver samples on receive clock falling edge
// - data-available sets per character, clear input
// - overrun when buffer reloaded before clear
// - receive outputs enabled by read-enable, right-justified
// - two selects give 5 to 8 bits
// - no-parity drops parity bit, forces fault low
// - sense selects odd or even parity
// - loopback uses test clock, wraps data, gates request
// - otherwise modem clocks/data, terminal enable gates request
// - control store is six 256x4 memories
// - load codes 000 to 011 decoded
// - load codes 100 to 111 decoded
// - test codes 0000 to 0111 selected
// - test codes 1000 to 1111 selected
// - function decoded only when jump bit zero
// - wait stalls, jump branches on test
// - function codes drive request, return, crc, flag
// - status request with active-low enables bits 3,4
// - start program loads all-ones sync first
// - idle program branches by control character
// - completion reports status then restarts at 0
// - block program routes characters to handlers
// - missing strobe sends sync and flags it
// - bit 12 with false test halts counter
// - bit 11 with true test loads jump address
// - return function loads counter from return register
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bos_map.svh"

module bos_output_sequencer #(
   parameter int TIMER_CYCLES = `BOS_TIMER_S * `BOS_CLK_HZ,
   parameter int STORE_DEPTH  = 256
) (
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // modem pins
   input  wire logic        modem_tx_clk,
   input  wire logic        modem_rx_clk,
   input  wire logic        modem_rx_data,
   input  wire logic        self_test_clock,
   input  wire logic        terminal_side_enable,
   output logic             tx_serial_line,
   output logic             sync_sent_flag,
   // receive character port
   input  wire logic        rx_avail_clear,
   input  wire logic        rx_read_enable,
   output logic      [7:0]  rx_char_out,
   output logic      [7:0]  rx_char_oe_n,
   output logic             rx_char_ready,
   output logic             rx_overrun_flag,
   output logic             rx_parity_fault,
   // service-request side
   input  wire logic [7:0]  out_shift_data,
   input  wire logic        out_shift_load_clk,
   input  wire logic        srl_busy,
   input  wire logic        read_strobe,
   input  wire logic        write_strobe,
   input  wire logic        strobe_done,
   input  wire logic        crc_shift_done,
   input  wire logic        byte_count_nz,
   output logic             out_data_request,
   output logic             status_input_request,
   output logic             status_underflow_en_n,
   output logic             status_done_en_n,
   output logic             crc_shift_right,
   output logic             crc_accum,
   output logic             crc_reset
);
   if (STORE_DEPTH != 256) $error("control store depth must be 256");
   if (TIMER_CYCLES < 1) $error("timer count must be at least one");

   bos_pkg::bos_word_s cw;
   bos_pkg::bos_mode_s mode_reg;
   bos_pkg::bos_rx_state_e rx_state_reg;
   logic [2:0]  ctrl_reg;
   logic [7:0]  pc_reg, store_addr_reg;
   logic        first_reg;
   logic [5:0]  ret_reg;
   logic        transparent_reg;
   logic [31:0] timer_reg;
   logic        timer_done_reg;
   logic [7:0]  tx_sync_reg, rx_sync_reg, tx_buf_reg;
   logic        tx_full_reg;
   logic [8:0]  tx_sh_reg, rx_sh_reg;
   logic [3:0]  tx_cnt_reg, rx_cnt_reg;
   logic [7:0]  rx_buf_reg;
   logic [2:0]  sync1_reg, sync2_reg, prev_reg;
   logic        test_sel, stall, take_jump, go_ret, tx_data_strobe, adv;
   logic [2:0]  function_field;
   logic [3:0]  dbits, fbits;
   logic [7:0]  dmask;
   logic        tclk, rclk, rdat, tx_rise, rx_fall, apb_acc;

   // control store: six nibble memories read in parallel, loaded over apb
   logic [23:0] store_word;
   logic        store_we;
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_nib
         logic [3:0] mem [0:STORE_DEPTH-1];
         always_ff @(posedge ref_clk) begin
            if (clk_en && store_we) begin
               mem[store_addr_reg] <= pwdata[4*g +: 4];
            end
         end
         assign store_word[4*g +: 4] = mem[pc_reg];
      end
   endgenerate
   assign cw = store_word;

   // line options
   assign dbits = 4'd5 + {2'b00, mode_reg.word_len_sel_hi, mode_reg.word_len_sel_lo};
   assign fbits = dbits + {3'b000, ~mode_reg.parity_disable};
   assign dmask = 8'hff >> (4'd8 - dbits);

   // pin synchronisers: tx clock, rx clock, rx data
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         prev_reg  <= 3'h0;
      end else if (clk_en) begin
         sync1_reg <= {modem_rx_data, modem_rx_clk, modem_tx_clk};
         sync2_reg <= sync1_reg;
         prev_reg  <= {sync2_reg[2:1], tclk};
      end
   end
   // test clock matches the modem clock stages through its own pair
   logic stc1_reg, stc2_reg, stc_prev_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stc1_reg     <= 1'b0;
         stc2_reg     <= 1'b0;
         stc_prev_reg <= 1'b0;
      end else if (clk_en) begin
         stc1_reg     <= self_test_clock;
         stc2_reg     <= stc1_reg;
         stc_prev_reg <= rclk;
      end
   end
   // loopback mux after synchronisation, so both sources see equal latency
   assign tclk = mode_reg.loopback_bit ? stc2_reg : sync2_reg[0];
   assign rclk = mode_reg.loopback_bit ? stc2_reg : sync2_reg[1];
   assign rdat = mode_reg.loopback_bit ? tx_serial_line : sync2_reg[2];
   assign tx_rise = tclk & ~prev_reg[0];
   assign rx_fall = ~rclk & stc_prev_reg;

   // test multiplexor
   always_comb begin
      unique case (cw.test)
         4'h0: test_sel = transparent_reg;
         4'h1: test_sel = ctrl_reg[`BOS_CTRL_XMIT];
         4'h2: test_sel = (cw.literal == out_shift_data);
         4'h3: test_sel = timer_done_reg;
         4'h4: test_sel = ctrl_reg[`BOS_CTRL_BLKCNT];
         4'h5: test_sel = mode_reg.transmit_test_bit;
         4'h6: test_sel = byte_count_nz;
         4'h7: test_sel = mode_reg.underrun_test_bit;
         4'h8: test_sel = sync_sent_flag;
         4'h9: test_sel = ~tx_full_reg;
         4'ha: test_sel = out_shift_load_clk;
         4'hb: test_sel = ~srl_busy;
         4'hc: test_sel = read_strobe;
         4'hd: test_sel = write_strobe;
         4'he: test_sel = crc_shift_done;
         4'hf: test_sel = strobe_done;
      endcase
   end

   // sequencing decisions
   assign function_field      = cw.jaddr[2:0];
   assign stall     = cw.wait_bit & ~test_sel;
   assign take_jump = cw.jump_bit & test_sel;
   assign go_ret    = ~cw.jump_bit & (function_field == 3'b001);
   assign adv       = ctrl_reg[`BOS_CTRL_RUN] & ~stall;
   // actions fire once, on the word's first cycle, so waits do not repeat them
   logic act;
   assign act = ctrl_reg[`BOS_CTRL_RUN] & first_reg;
   assign tx_data_strobe = act & ((cw.load == 3'b010) | (cw.load == 3'b101));

   // address counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pc_reg    <= 8'h00;
         first_reg <= 1'b1;
      end else if (clk_en) begin
         if (!ctrl_reg[`BOS_CTRL_RUN]) begin
            pc_reg    <= 8'h00;  // program starts at 0 with all-ones sync load
            first_reg <= 1'b1;
         end else if (adv) begin
            if (take_jump) pc_reg <= {1'b0, cw.jaddr};
            else if (go_ret) pc_reg <= {2'b00, ret_reg};
            else pc_reg <= pc_reg + 8'h01;
            first_reg <= 1'b1;
         end else begin
            first_reg <= 1'b0;
         end
      end
   end

   // load field: return, sync registers; function field: transparent flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ret_reg         <= 6'h00;
         tx_sync_reg     <= `BOS_SYNC_RST;
         rx_sync_reg     <= `BOS_SYNC_RST;
         transparent_reg <= 1'b0;
      end else if (clk_en && act) begin
         if (cw.load == 3'b011) ret_reg <= cw.literal[5:0];
         if (cw.load == 3'b100) tx_sync_reg <= cw.literal;
         if (cw.load == 3'b110) rx_sync_reg <= cw.literal;
         if (!cw.jump_bit && function_field == 3'b100) transparent_reg <= 1'b1;
         if (!cw.jump_bit && function_field == 3'b110) transparent_reg <= 1'b0;
      end
   end

   // one-second transmit timer, retriggered by load 001
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timer_reg      <= 32'h0;
         timer_done_reg <= 1'b0;
      end else if (clk_en) begin
         if (act && cw.load == 3'b001) begin
            timer_reg      <= 32'(TIMER_CYCLES);
            timer_done_reg <= 1'b0;
         end else if (timer_reg == 32'h1) begin
            timer_reg      <= 32'h0;
            timer_done_reg <= 1'b1;
         end else if (timer_reg != 32'h0) begin
            timer_reg <= timer_reg - 32'h1;
         end
      end
   end

   // function outputs to service-request and crc logic
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_data_request      <= 1'b0;
         status_input_request  <= 1'b0;
         status_underflow_en_n <= 1'b1;
         status_done_en_n      <= 1'b1;
         crc_shift_right       <= 1'b0;
         crc_accum             <= 1'b0;
         crc_reset             <= 1'b0;
      end else if (clk_en) begin
         // request gated by transmit bit in loopback, terminal enable otherwise
         out_data_request <= act & ~cw.jump_bit & (function_field == 3'b000)
                             & (mode_reg.loopback_bit ? ctrl_reg[`BOS_CTRL_XMIT]
                                                      : terminal_side_enable);
         status_input_request <= act & ~cw.jump_bit & (function_field == 3'b101);
         if (act && !cw.jump_bit && function_field == 3'b101) begin
            status_underflow_en_n <= cw.jaddr[3];
            status_done_en_n      <= cw.jaddr[4];
         end
         crc_shift_right <= act & ~cw.jump_bit & (function_field == 3'b010);
         crc_accum       <= act & ~cw.jump_bit & (function_field == 3'b011);
         crc_reset       <= act & ~cw.jump_bit & (function_field == 3'b110);
      end
   end

   // transmitter: double buffered, sync fill when no strobe arrived
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_buf_reg     <= 8'h00;
         tx_full_reg    <= 1'b0;
         tx_sh_reg      <= 9'h1ff;
         tx_cnt_reg     <= 4'h0;
         tx_serial_line <= 1'b1;
         sync_sent_flag <= 1'b0;
      end else if (clk_en) begin
         if (tx_rise) begin
            if (tx_cnt_reg == 4'h0) begin
               logic [7:0] ch;
               ch = tx_full_reg ? tx_buf_reg : tx_sync_reg;
               ch = ch & dmask;
               sync_sent_flag <= ~tx_full_reg;
               // odd parity sets the bit so the total count of ones is odd
               tx_sh_reg <= ({1'b0, ch} | ({8'h00, ^ch ^ ~mode_reg.parity_sense} << dbits))
                            >> 1;
               tx_serial_line <= ch[0];
               tx_cnt_reg     <= fbits - 4'h1;
            end else begin
               tx_serial_line <= tx_sh_reg[0];
               tx_sh_reg      <= tx_sh_reg >> 1;
               tx_cnt_reg     <= tx_cnt_reg - 4'h1;
            end
         end
         // a strobe in the load cycle keeps the buffer full with the new byte
         if (tx_data_strobe) begin
            tx_buf_reg  <= (cw.load == 3'b010) ? cw.literal : out_shift_data;
            tx_full_reg <= 1'b1;
         end else if (tx_rise && tx_cnt_reg == 4'h0) begin
            tx_full_reg <= 1'b0;
         end
      end
   end

   // receiver: hunt for sync, then count whole characters
   logic [8:0] rx_next;
   logic [7:0] rx_data;
   logic       rx_load;
   assign rx_next = (rx_sh_reg >> 1) | ({8'h00, rdat} << (fbits - 4'h1));
   assign rx_data = rx_next[7:0] & dmask;
   assign rx_load = rx_fall & ((rx_state_reg == bos_pkg::BOS_RX_HUNT) ?
                               (rx_data == (rx_sync_reg & dmask)) : (rx_cnt_reg == 4'h1));
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_state_reg    <= bos_pkg::BOS_RX_HUNT;
         rx_sh_reg       <= 9'h000;
         rx_cnt_reg      <= 4'h0;
         rx_buf_reg      <= 8'h00;
         rx_char_ready   <= 1'b0;
         rx_overrun_flag <= 1'b0;
         rx_parity_fault <= 1'b0;
      end else if (clk_en) begin
         if (rx_fall) begin
            rx_sh_reg  <= rx_load ? 9'h000 : rx_next;
            rx_cnt_reg <= (rx_load || rx_cnt_reg == 4'h0) ? fbits : rx_cnt_reg - 4'h1;
         end
         if (rx_load) begin
            rx_state_reg    <= bos_pkg::BOS_RX_CHAR;
            rx_buf_reg      <= rx_data;
            rx_overrun_flag <= rx_char_ready;
            rx_parity_fault <= ~mode_reg.parity_disable
                               & ((^rx_data ^ rx_next[dbits]) == mode_reg.parity_sense);
         end
         // a character landing with the clear keeps the flag set
         if (rx_load) rx_char_ready <= 1'b1;
         else if (rx_avail_clear) rx_char_ready <= 1'b0;
      end
   end

   // three-state receive outputs, enable low while driving
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_char_out  <= 8'h00;
         rx_char_oe_n <= 8'hff;
      end else if (clk_en) begin
         rx_char_out  <= rx_read_enable ? rx_buf_reg : 8'h00;
         rx_char_oe_n <= {8{~rx_read_enable}};
      end
   end

   // apb slave: no wait states, answer registered
   assign apb_acc  = psel & penable & pready;
   assign store_we = apb_acc & pwrite & (paddr == `BOS_PDATA_OFF);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr != `BOS_CTRL_OFF) & (paddr != `BOS_MODE_OFF)
                    & (paddr != `BOS_STATUS_OFF) & (paddr != `BOS_PADDR_OFF)
                    & (paddr != `BOS_PDATA_OFF);
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `BOS_CTRL_OFF:   prdata <= {29'h0, ctrl_reg};
               `BOS_MODE_OFF:   prdata <= {25'h0, mode_reg};
               `BOS_STATUS_OFF: prdata <= {8'h0, pc_reg, rx_buf_reg, timer_done_reg,
                                           transparent_reg, tx_full_reg, sync_sent_flag,
                                           rx_parity_fault, rx_overrun_flag, rx_char_ready,
                                           stall};
               `BOS_PADDR_OFF:  prdata <= {24'h0, store_addr_reg};
               default:         prdata <= 32'h0;
            endcase
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   // software registers; hardware clear of the transmit bit loses to a software set
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg       <= `BOS_CTRL_RST;
         mode_reg       <= `BOS_MODE_RST;
         store_addr_reg <= 8'h00;
      end else if (clk_en) begin
         if (act && cw.load == 3'b111) ctrl_reg[`BOS_CTRL_XMIT] <= 1'b0;
         if (apb_acc && pwrite) begin
            if (paddr == `BOS_CTRL_OFF) ctrl_reg <= pwdata[2:0];
            if (paddr == `BOS_MODE_OFF) mode_reg <= pwdata[6:0];
            if (paddr == `BOS_PADDR_OFF) store_addr_reg <= pwdata[7:0];
            if (paddr == `BOS_PDATA_OFF) store_addr_reg <= store_addr_reg + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

//--- verilog/bos_pkg.sv
// types shared by the output sequencer
package bos_pkg;
   // 24-bit output control word
   typedef struct packed {
      logic [7:0] literal;
      logic [2:0] load;
      logic       wait_bit;
      logic       jump_bit;
      logic [3:0] test;
      logic [6:0] jaddr;
   } bos_word_s;

   // line options from the mode register
   typedef struct packed {
      logic       parity_sense;
      logic       parity_disable;
      logic       word_len_sel_hi;
      logic       word_len_sel_lo;
      logic       underrun_test_bit;
      logic       transmit_test_bit;
      logic       loopback_bit;
   } bos_mode_s;

   typedef enum logic [1:0] {
      BOS_RX_HUNT = 2'b01,
      BOS_RX_CHAR = 2'b10
   } bos_rx_state_e;
endpackage
